// file: logic/sbsr_pkg.sv
// Package for the synchronous burst static memory block.
// Assumes a single clock domain; shared by the core and its helpers.
package sbsr_pkg;
  localparam int  SBSR_DEPTH      = 65536;
  localparam int  SBSR_ADDR_W     = 16;
  localparam int  SBSR_DATA_W     = 18;
  localparam int  SBSR_LANE_W     = 9;
  localparam int  SBSR_BURST_W    = 2;
  localparam int  SBSR_BUF_DEPTH  = 2;
  localparam logic [1:0] SBSR_BURST_STEP = 2'h1;
  localparam logic [15:0] SBSR_ADDR_RST  = 16'h0000;

  typedef enum logic [1:0]
  {
    SBSR_IDLE  = 2'b00,
    SBSR_READ  = 2'b01,
    SBSR_WRITE = 2'b11
  } sbsr_op_t;
endpackage : sbsr_pkg

// file: logic/sbsr_rd_if.sv
// Read data path carrier between core and output buffer.
// Assumes both ends on MCLK.
`timescale 1ns/1ps
`default_nettype none
interface sbsr_rd_if;
  import sbsr_pkg::*;
  logic                   valid;
  logic                   ready;
  logic [SBSR_DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sbsr_rd_if
`default_nettype wire

// file: logic/sbsr_array.sv
// Word array with per-lane write enables, combinational read.
// Assumes the caller presents a registered address and strobes.
`timescale 1ns/1ps
`default_nettype none
module sbsr_array
  import sbsr_pkg::*;
#(
  parameter int WORDS = SBSR_DEPTH
)
(
  input  wire logic                   clk,
  input  wire logic                   we_lo,
  input  wire logic                   we_hi,
  input  wire logic [SBSR_ADDR_W-1:0] addr,
  input  wire logic [SBSR_DATA_W-1:0] wdata,
  output logic      [SBSR_DATA_W-1:0] rdata
);
  initial
  begin
    if (WORDS < 1 || WORDS > SBSR_DEPTH)
      $error("sbsr_array: bad depth");
  end

  logic [SBSR_DATA_W-1:0] mem [WORDS];

  // Self-timed write: stored on the edge, no pulse from outside
  always_ff @(posedge clk)
  begin
    if (we_lo)
      mem[addr][SBSR_LANE_W-1:0] <= wdata[SBSR_LANE_W-1:0];
    if (we_hi)
      mem[addr][SBSR_DATA_W-1:SBSR_LANE_W] <= wdata[SBSR_DATA_W-1:SBSR_LANE_W];
  end

  always_comb
  begin
    rdata = mem[addr];
  end
endmodule : sbsr_array
`default_nettype wire

// file: logic/sbsr_rdbuf.sv
// Two-entry skid buffer for read words.
// Assumes a single clock and an active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module sbsr_rdbuf
  import sbsr_pkg::*;
#(
  parameter int DEPTH = SBSR_BUF_DEPTH
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  sbsr_rd_if.snk    up,
  sbsr_rd_if.src    dn
);
  initial
  begin
    if (DEPTH != 2)
      $error("sbsr_rdbuf: depth must be 2");
  end

  logic [SBSR_DATA_W-1:0] slot_q [DEPTH];
  logic                   wp_q;
  logic                   rp_q;
  logic [1:0]             cnt_q;
  logic                   push;
  logic                   pop;

  assign up.ready = (cnt_q != 2'h2);
  assign dn.valid = (cnt_q != 2'h0);
  assign dn.data  = slot_q[rp_q];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  always_ff @(posedge clk)
  begin
    if (push)
      slot_q[wp_q] <= up.data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_no_overfill : assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= 2'h2)
    else $error("read buffer overfilled");
endmodule : sbsr_rdbuf
`default_nettype wire

// file: logic/sbsr_core.sv
// Synchronous burst static memory, 64K words of 18 bits, with burst counter.
// Assumes all inputs but OE_N are synchronous to MCLK; the bench resolves DATA_IO.
//
// Contract
// - Store 65536 words of 18 bits
// - Register address, data and controls on edge
// - Either start input begins a burst
// - Two-bit counter supplies low address bits
// - Writes self-timed from the clock edge
// - Byte strobes gate their own nine bits
// - Processor start forces read at new address
// - Controller start loads address, reads or writes
// - Chip select sampled only on start
// - Advance low steps address before access
// - Advance high repeats access, wait state
// - Burst wraps to its loaded start value
// - Counter loads and steps A1,A0 only
// - Controller start writes if any strobe low
// - Continuation ignores chip select, strobes decide
// - Drive data only on read with OE low
// - Data pins released after power-up
`timescale 1ns/1ps
`default_nettype none
module sbsr_core
  import sbsr_pkg::*;
(
  input  wire logic                   MCLK,
  input  wire logic                   RSTN,
  input  wire logic [SBSR_ADDR_W-1:0] ADDR_IN,
  input  wire logic                   CHIP_SEL_N,
  input  wire logic                   PROCESSOR_BURST_START_N,
  input  wire logic                   CONTROLLER_BURST_START_N,
  input  wire logic                   BURST_ADVANCE_N,
  input  wire logic                   LOWER_BYTE_WRITE_N,
  input  wire logic                   UPPER_BYTE_WRITE_N,
  input  wire logic                   OE_N,
  input  wire logic                   READ_ACCEPT,
  input  wire logic [SBSR_DATA_W-1:0] DATA_IO_IN,
  output logic      [SBSR_DATA_W-1:0] DATA_IO_OUT,
  output logic                        DATA_IO_OE,
  output logic                        READ_VALID,
  output logic      [SBSR_DATA_W-1:0] READ_WORD
);
  // Input registers
  logic [SBSR_ADDR_W-1:0] addr_q;
  logic [SBSR_DATA_W-1:0] din_q;
  logic                   cs_n_q;
  logic                   psn_q;
  logic                   csn_q;
  logic                   adv_n_q;
  logic                   lw_n_q;
  logic                   uw_n_q;
  logic                   first_q;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      addr_q  <= SBSR_ADDR_RST;
      din_q   <= '0;
      cs_n_q  <= 1'b1;
      psn_q   <= 1'b1;
      csn_q   <= 1'b1;
      adv_n_q <= 1'b1;
      lw_n_q  <= 1'b1;
      uw_n_q  <= 1'b1;
      first_q <= 1'b0;
    end
    else
    begin
      addr_q  <= ADDR_IN;
      din_q   <= DATA_IO_IN;
      cs_n_q  <= CHIP_SEL_N;
      psn_q   <= PROCESSOR_BURST_START_N;
      csn_q   <= CONTROLLER_BURST_START_N;
      adv_n_q <= BURST_ADVANCE_N;
      lw_n_q  <= LOWER_BYTE_WRITE_N;
      uw_n_q  <= UPPER_BYTE_WRITE_N;
      first_q <= 1'b1;
    end
  end

  // Decode of the registered cycle
  logic start;
  logic any_wr;
  logic cont;
  assign start  = first_q && (!psn_q || !csn_q);
  assign any_wr = !lw_n_q || !uw_n_q;
  assign cont   = first_q && psn_q && csn_q;

  // Burst state: base upper bits, loaded start, counter, selected flag
  logic [SBSR_ADDR_W-1:SBSR_BURST_W] base_q;
  logic [SBSR_BURST_W-1:0]           start_q;
  logic [SBSR_BURST_W-1:0]           cnt_q;
  logic                              sel_q;
  logic [SBSR_BURST_W-1:0]           cnt_d;
  logic [SBSR_BURST_W-1:0]           cnt_use;
  logic [SBSR_ADDR_W-1:SBSR_BURST_W] base_use;
  logic                              sel_use;

  always_comb
  begin
    cnt_d = cnt_q + SBSR_BURST_STEP;
    if (cnt_d == start_q)
      cnt_d = start_q;
  end

  always_comb
  begin
    if (start)
    begin
      base_use = addr_q[SBSR_ADDR_W-1:SBSR_BURST_W];
      cnt_use  = addr_q[SBSR_BURST_W-1:0];
      sel_use  = !cs_n_q;
    end
    else if (cont && !adv_n_q)
    begin
      base_use = base_q;
      cnt_use  = cnt_d;
      sel_use  = sel_q;
    end
    else
    begin
      base_use = base_q;
      cnt_use  = cnt_q;
      sel_use  = sel_q && cont;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      base_q  <= '0;
      start_q <= '0;
      cnt_q   <= '0;
      sel_q   <= 1'b0;
    end
    else
    begin
      base_q <= base_use;
      cnt_q  <= cnt_use;
      sel_q  <= sel_use;
      if (start)
        start_q <= addr_q[SBSR_BURST_W-1:0];
    end
  end

  // Operation of this cycle
  sbsr_op_t op;
  always_comb
  begin
    if (!sel_use)
      op = SBSR_IDLE;
    else if (!psn_q)
      op = SBSR_READ;
    else if (any_wr)
      op = SBSR_WRITE;
    else
      op = SBSR_READ;
  end

  logic [SBSR_ADDR_W-1:0] acc_addr;
  logic [SBSR_DATA_W-1:0] arr_rd;
  logic                   we_lo;
  logic                   we_hi;
  assign acc_addr = {base_use, cnt_use};
  assign we_lo    = (op == SBSR_WRITE) && !lw_n_q;
  assign we_hi    = (op == SBSR_WRITE) && !uw_n_q;

  sbsr_array #(.WORDS(SBSR_DEPTH)) u_array
  (
    .clk   (MCLK),
    .we_lo (we_lo),
    .we_hi (we_hi),
    .addr  (acc_addr),
    .wdata (din_q),
    .rdata (arr_rd)
  );

  // Read word register; pins show it only while reading with OE low
  logic [SBSR_DATA_W-1:0] rd_q;
  logic                   rd_act_q;
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rd_q     <= '0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      rd_act_q <= (op == SBSR_READ);
      if (op == SBSR_READ)
        rd_q <= arr_rd;
    end
  end

  // OE is combinational on purpose: it acts without the clock
  assign DATA_IO_OUT = rd_q;
  assign DATA_IO_OE  = rd_act_q && !OE_N && (op != SBSR_WRITE);

  // Read words also leave through a skid buffer; a full buffer drops the word
  // from this copy only, because the pin path never stalls.
  sbsr_rd_if rd_up ();
  sbsr_rd_if rd_dn ();
  assign rd_up.valid = rd_act_q;
  assign rd_up.data  = rd_q;
  assign rd_dn.ready = READ_ACCEPT;
  assign READ_VALID  = rd_dn.valid;
  assign READ_WORD   = rd_dn.data;

  sbsr_rdbuf #(.DEPTH(SBSR_BUF_DEPTH)) u_rdbuf
  (
    .clk   (MCLK),
    .rst_n (RSTN),
    .up    (rd_up.snk),
    .dn    (rd_dn.src)
  );

  // Checks
  a_psn_forces_read : assert property (@(posedge MCLK) disable iff (!RSTN)
    (first_q && !psn_q && !cs_n_q) |-> (op == SBSR_READ))
    else $error("processor start did not read");
  a_csel_deselect : assert property (@(posedge MCLK) disable iff (!RSTN)
    (start && cs_n_q) |-> (op == SBSR_IDLE && !we_lo && !we_hi))
    else $error("deselect not honoured");
  a_adv_steps : assert property (@(posedge MCLK) disable iff (!RSTN)
    (cont && !adv_n_q) |=> (cnt_q == $past(cnt_d)))
    else $error("advance did not step");
  a_wait_holds : assert property (@(posedge MCLK) disable iff (!RSTN)
    (cont && adv_n_q) |-> (cnt_use == cnt_q))
    else $error("wait state moved address");
  a_ctl_write : assert property (@(posedge MCLK) disable iff (!RSTN)
    (first_q && psn_q && !csn_q && !cs_n_q && any_wr) |-> (op == SBSR_WRITE))
    else $error("controller write missed");
  a_lane_gate : assert property (@(posedge MCLK) disable iff (!RSTN)
    (we_lo == (op == SBSR_WRITE && !lw_n_q)) && (we_hi == (op == SBSR_WRITE && !uw_n_q)))
    else $error("lane strobe mismatch");
  a_oe_gate : assert property (@(posedge MCLK) disable iff (!RSTN)
    (OE_N || op == SBSR_WRITE) |-> !DATA_IO_OE)
    else $error("pins driven when disabled");
  a_start_load : assert property (@(posedge MCLK) disable iff (!RSTN)
    start |=> (cnt_q == $past(addr_q[1:0]) && start_q == $past(addr_q[1:0])))
    else $error("counter start not loaded");

  // The lane split and the two-bit counter are wired in, so other widths are refused
  initial
  begin
    if (SBSR_DATA_W != 2 * SBSR_LANE_W || SBSR_BURST_W != 2)
      $error("sbsr_core: lane or burst width unsupported");
    if ((1 << SBSR_ADDR_W) != SBSR_DEPTH)
      $error("sbsr_core: depth does not match address width");
  end

  // Further behaviours; the step, hold, deselect and read checks use named sequences
  sequence s_step;
    cont && !adv_n_q;
  endsequence
  sequence s_hold;
    cont && adv_n_q;
  endsequence
  sequence s_desel_start;
    start && cs_n_q;
  endsequence
  sequence s_read_issued;
    op == SBSR_READ;
  endsequence
  sequence s_pins_open;
    !OE_N && op != SBSR_WRITE;
  endsequence

  // Wrap to the start value follows from a plain modulo-four step
  a_step_mod_four : assert property (@(posedge MCLK) disable iff (!RSTN)
    s_step |=> (cnt_q == $past(cnt_q) + SBSR_BURST_STEP))
    else $error("counter did not step by one");
  a_wait_keeps_base : assert property (@(posedge MCLK) disable iff (!RSTN)
    s_hold |=> (cnt_q == $past(cnt_q) && base_q == $past(base_q)))
    else $error("wait state changed the address");
  a_desel_sticks : assert property (@(posedge MCLK) disable iff (!RSTN)
    s_desel_start ##1 cont |-> (op == SBSR_IDLE))
    else $error("deselect lost during continuation");
  a_read_on_pins : assert property (@(posedge MCLK) disable iff (!RSTN)
    s_read_issued ##1 s_pins_open |-> DATA_IO_OE)
    else $error("read word not driven");
  a_idle_quiet : assert property (@(posedge MCLK) disable iff (!RSTN)
    !rd_act_q |-> !DATA_IO_OE)
    else $error("pins driven without a read");
  a_wr_pins_off : assert property (@(posedge MCLK) disable iff (!RSTN)
    (we_lo || we_hi) |-> !DATA_IO_OE)
    else $error("pins driven during a write");
  a_psn_no_write : assert property (@(posedge MCLK) disable iff (!RSTN)
    (first_q && !psn_q) |-> (!we_lo && !we_hi))
    else $error("processor start wrote");
  a_base_in_burst : assert property (@(posedge MCLK) disable iff (!RSTN)
    s_step |=> (base_q == $past(base_q)))
    else $error("burst moved the upper address");
  a_cont_keeps_sel : assert property (@(posedge MCLK) disable iff (!RSTN)
    (cont && sel_q && !adv_n_q) |-> sel_use)
    else $error("chip select not ignored mid-burst");
endmodule : sbsr_core
`default_nettype wire

// file: bench/sbsr_host.sv
// Host model: issues one bus cycle per clock and resolves the data pins.
// Assumes the bench calls cyc from one thread, once per clock.
`timescale 1ns/1ps
`default_nettype none
module sbsr_host
  import sbsr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [SBSR_DATA_W-1:0] data_out,
  input  wire logic                   data_oe,
  output logic      [SBSR_ADDR_W-1:0] addr,
  output logic      [6:0]             ctl,
  output logic      [SBSR_DATA_W-1:0] bus
);
  logic [SBSR_DATA_W-1:0] wd;
  logic                   wen;
  logic [SBSR_DATA_W-1:0] last_q;
  // Released pins flip, so a stale word can never pass for a read
  assign bus = data_oe ? data_out : (wen ? wd : ~last_q);
  always_ff @(posedge clk) last_q <= bus;
  initial
  begin
    addr = '0;
    ctl  = 7'h7F;
    wen  = 1'b0;
    wd   = '0;
  end
  // Control bits: chip select, two starts, advance, two strobes, output enable
  task automatic cyc(input logic [15:0] a, input logic [6:0] c, input logic [17:0] d);
    @(posedge clk);
    addr <= a;
    ctl  <= c | {6'h00, ~&c[2:1]};
    wen  <= ~&c[2:1];
    wd   <= d;
  endtask : cyc
endmodule : sbsr_host
`default_nettype wire

// file: bench/test_sync_burst_sram_64kx18.sv
// Bench for the burst static memory: one hand-written task per scenario.
// Assumes the host model drives all pins except clock, reset and the read stream ready.
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_64kx18;
  import sbsr_pkg::*;
  localparam logic [6:0] RD = 7'h2E, WR = 7'h28, SR = 7'h3E, CR = 7'h36, DS = 7'h6E;
  logic                   mclk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   accept = 1'b0;
  logic [SBSR_ADDR_W-1:0] addr;
  logic [6:0]             ctl;
  logic [SBSR_DATA_W-1:0] bus;
  logic [SBSR_DATA_W-1:0] dout;
  logic                   doe;
  logic                   rvalid;
  logic [SBSR_DATA_W-1:0] rword;
  int                     error_cnt = 0;
  int                     samples_checked = 0;

  always #25 mclk = ~mclk;

  sbsr_host i_host (.clk(mclk), .data_out(dout), .data_oe(doe), .addr(addr), .ctl(ctl),
                    .bus(bus));
  sbsr_core i_dut (.MCLK(mclk), .RSTN(rstn), .ADDR_IN(addr), .CHIP_SEL_N(ctl[6]),
    .PROCESSOR_BURST_START_N(ctl[5]), .CONTROLLER_BURST_START_N(ctl[4]),
    .BURST_ADVANCE_N(ctl[3]), .LOWER_BYTE_WRITE_N(ctl[2]), .UPPER_BYTE_WRITE_N(ctl[1]),
    .OE_N(ctl[0]), .READ_ACCEPT(accept), .DATA_IO_IN(bus), .DATA_IO_OUT(dout),
    .DATA_IO_OE(doe), .READ_VALID(rvalid), .READ_WORD(rword));

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic flag(input logic got, input logic exp);
    cmp({17'h0_0000, got}, {17'h0_0000, exp});
  endtask : flag

  // Access, one suspend, then the word of the access is on the pins
  task automatic rd(input logic [15:0] a, input logic [6:0] c, input logic [17:0] exp);
    i_host.cyc(a, c, 18'h0_0000);
    i_host.cyc(a, SR, 18'h0_0000);
    @(posedge mclk);
    @(negedge mclk);
    flag(doe, 1'b1);
    cmp(bus, exp);
  endtask : rd

  task automatic s_bytes;
    i_host.cyc(16'h0101, WR, 18'h2_5A5A);
    rd(16'h0101, RD, 18'h2_5A5A);
    i_host.cyc(16'h0101, 7'h2A, 18'h3_FFFF);
    rd(16'h0101, RD, 18'h2_5BFF);
    i_host.cyc(16'h0101, 7'h2C, 18'h0_0000);
    rd(16'h0101, RD, 18'h0_01FF);
  endtask : s_bytes

  task automatic s_burst;
    i_host.cyc(16'h0202, WR, 18'h0_1002);
    i_host.cyc(16'h0000, 7'h30, 18'h0_1003);
    i_host.cyc(16'h0000, 7'h30, 18'h0_1000);
    i_host.cyc(16'h0000, 7'h30, 18'h0_1001);
    rd(16'h0202, RD, 18'h0_1002);
    for (int i = 1; i < 5; i++)
    begin
      // Chip select high mid-burst must not stop the walk
      rd(16'h0000, (i == 2) ? 7'h76 : CR, 18'h0_1000 | 18'((2 + i) % 4));
    end
  endtask : s_burst

  task automatic s_proc;
    rd(16'h0101, 7'h08, 18'h0_01FF);
    rd(16'h0101, RD, 18'h0_01FF);
    i_host.cyc(16'h0303, 7'h1E, 18'h0_0000);
    i_host.cyc(16'h0000, 7'h38, 18'h1_2345);
    rd(16'h0303, RD, 18'h1_2345);
  endtask : s_proc

  task automatic s_off;
    i_host.cyc(16'h0303, RD, 18'h0_0000);
    i_host.cyc(16'h0000, 7'h3F, 18'h0_0000);
    @(posedge mclk);
    @(negedge mclk);
    flag(doe, 1'b0);
    i_host.cyc(16'h0101, 7'h68, 18'h3_3333);
    i_host.cyc(16'h0000, SR, 18'h0_0000);
    @(posedge mclk);
    @(negedge mclk);
    flag(doe, 1'b0);
    rd(16'h0101, RD, 18'h0_01FF);
  endtask : s_off

  // Two words fill the buffer; the third is dropped from the stream only
  task automatic s_buf;
    i_host.cyc(16'h0000, DS, 18'h0_0000);
    accept <= 1'b1;
    repeat (4) @(posedge mclk);
    accept <= 1'b0;
    i_host.cyc(16'h0101, RD, 18'h0_0000);
    i_host.cyc(16'h0000, DS, 18'h0_0000);
    i_host.cyc(16'h0202, RD, 18'h0_0000);
    i_host.cyc(16'h0000, DS, 18'h0_0000);
    i_host.cyc(16'h0303, RD, 18'h0_0000);
    i_host.cyc(16'h0000, DS, 18'h0_0000);
    repeat (3) @(posedge mclk);
    accept <= 1'b1;
    @(negedge mclk);
    flag(rvalid, 1'b1);
    cmp(rword, 18'h0_01FF);
    @(negedge mclk);
    cmp(rword, 18'h0_1002);
    @(negedge mclk);
    flag(rvalid, 1'b0);
  endtask : s_buf

  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    flag(doe, 1'b0);
    flag(rvalid, 1'b0);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    s_bytes();
    s_burst();
    s_proc();
    s_off();
    s_buf();
    final_report();
  end
endmodule : test_sync_burst_sram_64kx18
`default_nettype wire
